// ==== pkg/zrc_pkg.sv ====
package zrc_pkg;

  // ---------------------------------------------------------------
  // sizes and bus
  // ---------------------------------------------------------------
  localparam int ZONES = 2;
  localparam int AW    = 8;
  localparam int TW    = 16;
  localparam int JCW   = 16;
  localparam int INT_W = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // register map: one block per zone, then the interrupt pair
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] ZONE_STRIDE  = 8'h20;
  localparam logic [AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [AW-1:0] OFS_GAP      = 8'h04;
  localparam logic [AW-1:0] OFS_ACCEPT   = 8'h08;
  localparam logic [AW-1:0] OFS_JAMT     = 8'h0C;
  localparam logic [AW-1:0] OFS_STAT     = 8'h10;
  localparam logic [AW-1:0] OFS_JCNT     = 8'h14;
  localparam logic [AW-1:0] OFS_CMD      = 8'h18;
  localparam logic [AW-1:0] OFS_INT_STAT = 8'h40;
  localparam logic [AW-1:0] OFS_INT_MASK = 8'h44;

  // control word fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TZONE    = 2;
  localparam int CTRL_ACDIS    = 3;
  localparam int CTRL_ACCUM    = 4;
  localparam int CMD_CLEAR     = 0;
  // interrupt bits: jam occurrence per zone, auto clear give-up per zone
  localparam int INT_JAM_LSB    = 0;
  localparam int INT_GIVEUP_LSB = 2;

  // release modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_TRAIN  = 2'h1;
  localparam logic [1:0] MODE_GAP    = 2'h2;

  // ---------------------------------------------------------------
  // timing: timers count 10 ms ticks
  // ---------------------------------------------------------------
  localparam int TICK_MS       = 10;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_CYC_DFLT = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [TW-1:0]  GAP_RST       = 16'h0000;
  localparam logic [TW-1:0]  ACCEPT_RST    = 16'h0000;
  localparam logic [TW-1:0]  JAMT_RST      = 16'h00C8;
  localparam logic [TW-1:0]  AUTOCLR_TICKS = 16'h01F4;
  localparam logic [1:0]     AUTOCLR_TRIES = 2'h3;
  localparam logic [JCW-1:0] JCNT_MAX      = 16'hFFFF;

  // ---------------------------------------------------------------
  // zone sequencing states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ZS_EMPTY,
    ZS_ACCEPT,
    ZS_ARRIVED,
    ZS_HOLD,
    ZS_GAP,
    ZS_RUN,
    ZS_JAMMED
  } zrc_state_e;

endpackage

// ==== hw/zrc_timer.sv ====
module zrc_timer
  import zrc_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire logic          tick,
  input  wire logic          load,
  input  wire logic [TW-1:0] load_val,
  output logic               done
);

  logic [TW-1:0] cnt;

  // down counter in ticks; first tick may land early by up to one tick
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      cnt <= '0;
    else if (load)
      cnt <= load_val;
    else if (tick && cnt != '0)
      cnt <= cnt - 1'b1;
  end

  assign done = (cnt == '0); // load is built from done, no loop back

endmodule

// ==== hw/zrc_axil.sv ====
module zrc_axil
  import zrc_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          reset_n,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               wr_en,
  output logic [AW-1:0]      wr_addr,
  output logic [31:0]        wr_data,
  output logic [3:0]         wr_strb,
  input  wire logic          wr_hit,
  output logic [AW-1:0]      rd_addr,
  input  wire logic [31:0]   rd_data,
  input  wire logic          rd_hit
);

  logic aw_full;
  logic w_full;
  logic ar_full;

  assign s_axi_awready = !aw_full;
  assign s_axi_wready  = !w_full;
  assign s_axi_arready = !ar_full && !s_axi_rvalid;
  // commit only once the previous response has gone
  assign wr_en = aw_full && w_full && !s_axi_bvalid;

  // write address and data are held independently, in either order
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full)
      begin
        aw_full <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      else if (wr_en)
        aw_full <= 1'b0;
      if (s_axi_wvalid && !w_full)
      begin
        w_full  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      else if (wr_en)
        w_full <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_en)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read: address in one cycle, registered data the next
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ar_full      <= 1'b0;
      rd_addr      <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      ar_full <= 1'b1;
      rd_addr <= s_axi_araddr;
    end
    else if (ar_full)
    begin
      ar_full      <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// ==== hw/zrc_zone_ctrl.sv ====
// Functional notes
// - gap mode: held carton leaves after downstream release and gap expiry
// - gap timer never delays a carton in transit, only held ones
// - each gap zone waits its own gap timer, delays add up
// - accepting zone starts motor accept time after sensor blocks
// - accept delay applies only to a zone set as accepting
// - jam output is high for arrival jam or sensor jam
// - jam counter counts every jam, saturating at JCNT_MAX, cleared only by power cycle
// - clear command clears a sensor jam with the carton still there
// - with auto clear on, clear restarts the auto clear procedure
// - accumulate stops the next carton until accumulate is removed
// - host accumulate is kept in flash and restored at power-up
// - new release mode acts at once, no restart
// - reset default is single carton release mode
// - auto clear makes at most 3 attempts before staying jammed
module zrc_zone_ctrl
  import zrc_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DFLT
)
(
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [AW-1:0]    s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [AW-1:0]    s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire logic [ZONES-1:0] sensor_blocked,
  input  wire logic [ZONES-1:0] ds_clear,
  input  wire logic [ZONES-1:0] ds_release,
  input  wire logic [ZONES-1:0] arrival_jam,
  input  wire logic [ZONES-1:0] nv_accum_in,
  output logic [ZONES-1:0]      motor_run,
  output logic [ZONES-1:0]      zone_release,
  output logic [ZONES-1:0]      zone_empty,
  output logic [ZONES-1:0]      jam_active,
  output logic [ZONES-1:0]      nv_accum_out,
  output logic [ZONES-1:0]      nv_save,
  output logic                  irq
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic zreg(input logic [AW-1:0] a,
                                input logic          z,
                                input logic [AW-1:0] ofs);
    return a == (z ? ofs + ZONE_STRIDE : ofs);
  endfunction

  function automatic logic addr_ok(input logic [AW-1:0] a);
    return (a[AW-1:6] == '0 && a[4:0] <= OFS_CMD[4:0] && a[1:0] == 2'h0)
           || a == OFS_INT_STAT || a == OFS_INT_MASK;
  endfunction

  function automatic logic [TW-1:0] merge16(input logic [TW-1:0] old,
                                            input logic [31:0]   d,
                                            input logic [3:0]    s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ---------------------------------------------------------------
  // bus front end
  // ---------------------------------------------------------------
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0]   wr_data;
  logic [3:0]    wr_strb;
  logic [AW-1:0] rd_addr;
  logic [31:0]   rd_data;

  zrc_axil u_axil (
    .mclk          (mclk),
    .reset_n       (reset_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_hit        (addr_ok(wr_addr)),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_hit        (addr_ok(rd_addr))
  );

  // ---------------------------------------------------------------
  // shared tick prescaler
  // ---------------------------------------------------------------
  logic [31:0] tick_cnt;
  logic        tick;

  assign tick = (tick_cnt == 32'(TICK_CYC - 1));

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      tick_cnt <= '0;
    else if (tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 32'h1;
  end

  // ---------------------------------------------------------------
  // per-zone settings, state and status
  // ---------------------------------------------------------------
  logic [ZONES-1:0][1:0]     mode;
  logic [ZONES-1:0]          tzone_en;
  logic [ZONES-1:0]          acdis;
  logic [ZONES-1:0]          accum;
  logic [ZONES-1:0][TW-1:0]  gap_time;
  logic [ZONES-1:0][TW-1:0]  accept_time;
  logic [ZONES-1:0][TW-1:0]  jam_time;
  logic [ZONES-1:0][JCW-1:0] jam_cnt;
  logic [ZONES-1:0][TW-1:0]  stat_word;
  logic [ZONES-1:0]          jam_evt;
  logic [ZONES-1:0]          giveup_evt;
  logic                      nv_loaded;

  // flash copy is taken on the first edge after reset release
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      nv_loaded <= 1'b0;
    else
      nv_loaded <= 1'b1;
  end

  assign nv_accum_out = accum;

  for (genvar z = 0; z < ZONES; z++)
  begin : g_zone
    zrc_state_e state;
    zrc_state_e next_state;
    logic       sens_q;
    logic       arr_q;
    logic       tmr_load;
    logic       tmr_done;
    logic [TW-1:0] tmr_val;
    logic [1:0] tries;
    logic       clr_cmd;
    logic       ctrl_wr;
    logic       evt_sj;
    logic       evt_aj;
    logic [JCW:0] cnt_sum;

    assign ctrl_wr = wr_en && wr_strb[0] && zreg(wr_addr, 1'(z), OFS_CTRL);
    assign clr_cmd = wr_en && wr_strb[0] && wr_data[CMD_CLEAR]
                     && zreg(wr_addr, 1'(z), OFS_CMD);

    // settings of this zone only, reset to single carton release
    always_ff @(posedge mclk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        mode[z]        <= MODE_SINGLE;
        tzone_en[z]    <= 1'b0;
        acdis[z]       <= 1'b0;
        gap_time[z]    <= GAP_RST;
        accept_time[z] <= ACCEPT_RST;
        jam_time[z]    <= JAMT_RST;
      end
      else if (wr_en)
      begin
        if (ctrl_wr)
        begin
          mode[z]     <= wr_data[CTRL_MODE_LSB +: 2];
          tzone_en[z] <= wr_data[CTRL_TZONE];
          acdis[z]    <= wr_data[CTRL_ACDIS];
        end
        if (zreg(wr_addr, 1'(z), OFS_GAP))
          gap_time[z] <= merge16(gap_time[z], wr_data, wr_strb);
        if (zreg(wr_addr, 1'(z), OFS_ACCEPT))
          accept_time[z] <= merge16(accept_time[z], wr_data, wr_strb);
        if (zreg(wr_addr, 1'(z), OFS_JAMT))
          jam_time[z] <= merge16(jam_time[z], wr_data, wr_strb);
      end
    end

    // accumulate: restored from flash, saved on every host change
    always_ff @(posedge mclk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        accum[z]   <= 1'b0;
        nv_save[z] <= 1'b0;
      end
      else if (!nv_loaded)
      begin
        accum[z]   <= nv_accum_in[z];
        nv_save[z] <= 1'b0;
      end
      else
      begin
        if (ctrl_wr)
          accum[z] <= wr_data[CTRL_ACCUM];
        nv_save[z] <= ctrl_wr && (wr_data[CTRL_ACCUM] != accum[z]);
      end
    end

    // sequencing; mode is read live so a new mode acts at once
    always_comb
    begin
      next_state = state;
      unique case (state)
        ZS_EMPTY:
          if (sensor_blocked[z] && !sens_q)
            next_state = tzone_en[z] ? ZS_ACCEPT : ZS_ARRIVED;
        ZS_ACCEPT:
          if (tmr_done)
            next_state = ZS_ARRIVED;
        ZS_ARRIVED:
          // a carton passing through goes on with no gap wait
          if (accum[z] || !ds_clear[z])
            next_state = ZS_HOLD;
          else
            next_state = ZS_RUN;
        ZS_HOLD:
          if (!accum[z])
          begin
            if (mode[z] == MODE_TRAIN)
            begin
              if (ds_release[z] || ds_clear[z])
                next_state = ZS_RUN;
            end
            else if (mode[z] == MODE_GAP)
            begin
              if (ds_release[z] || ds_clear[z])
                next_state = ZS_GAP;
            end
            else if (ds_clear[z])
              next_state = ZS_RUN;
          end
        ZS_GAP:
          if (accum[z])
            next_state = ZS_HOLD;
          else if (tmr_done)
            next_state = ZS_RUN;
        ZS_RUN:
          if (!sensor_blocked[z])
            next_state = ZS_EMPTY;
          else if (tmr_done)
            next_state = ZS_JAMMED;
        ZS_JAMMED:
          if (!sensor_blocked[z])
            next_state = ZS_EMPTY;
          else if (clr_cmd)
            next_state = ZS_ARRIVED;
          else if (!acdis[z] && tries != AUTOCLR_TRIES && tmr_done)
            next_state = ZS_RUN;
        default:
          next_state = ZS_EMPTY;
      endcase
    end

    // one timer per zone, reloaded on every state change
    assign tmr_load = (next_state != state);

    always_comb
    begin
      unique case (next_state)
        ZS_ACCEPT: tmr_val = accept_time[z];
        ZS_GAP:    tmr_val = gap_time[z];
        ZS_RUN:    tmr_val = jam_time[z];
        ZS_JAMMED: tmr_val = AUTOCLR_TICKS;
        default:   tmr_val = '0;
      endcase
    end

    zrc_timer u_tmr (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .tick     (tick),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done)
    );

    // state, retry count and edge history
    always_ff @(posedge mclk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        state  <= ZS_EMPTY;
        tries  <= 2'h0;
        sens_q <= 1'b0;
        arr_q  <= 1'b0;
      end
      else
      begin
        state  <= next_state;
        sens_q <= sensor_blocked[z];
        arr_q  <= arrival_jam[z];
        if (clr_cmd && state == ZS_JAMMED)
          tries <= 2'h0;
        else if (state == ZS_JAMMED && next_state == ZS_RUN)
          tries <= tries + 2'h1;
        else if (next_state == ZS_EMPTY)
          tries <= 2'h0;
      end
    end

    // registered zone outputs
    always_ff @(posedge mclk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        motor_run[z]    <= 1'b0;
        zone_release[z] <= 1'b0;
        zone_empty[z]   <= 1'b1;
        jam_active[z]   <= 1'b0;
      end
      else
      begin
        motor_run[z]    <= (next_state == ZS_RUN);
        zone_release[z] <= (next_state == ZS_RUN) && (state == ZS_HOLD
                           || state == ZS_GAP || state == ZS_ARRIVED);
        zone_empty[z]   <= (next_state == ZS_EMPTY);
        jam_active[z]   <= (next_state == ZS_JAMMED) || arrival_jam[z];
      end
    end

    // jam occurrences; both kinds in one cycle count twice
    assign evt_sj  = (next_state == ZS_JAMMED) && (state != ZS_JAMMED);
    assign evt_aj  = arrival_jam[z] && !arr_q;
    assign cnt_sum = {1'b0, jam_cnt[z]} + (JCW + 1)'(evt_sj)
                     + (JCW + 1)'(evt_aj);
    assign jam_evt[z]    = evt_sj || evt_aj;
    // a hopeless jam: auto clear off or all attempts spent
    assign giveup_evt[z] = evt_sj && (acdis[z] || tries == AUTOCLR_TRIES);

    // only reset_n, i.e. a power cycle, clears the counter
    always_ff @(posedge mclk or negedge reset_n)
    begin
      if (!reset_n)
        jam_cnt[z] <= '0;
      else if (cnt_sum[JCW])
        jam_cnt[z] <= JCNT_MAX;
      else
        jam_cnt[z] <= cnt_sum[JCW-1:0];
    end

    assign stat_word[z] = {1'b0, accum[z] && state == ZS_HOLD,
                           sensor_blocked[z], motor_run[z],
                           2'h0, tries,
                           1'b0, arrival_jam[z], state == ZS_JAMMED,
                           jam_active[z], 1'b0, state};
  end

  // ---------------------------------------------------------------
  // interrupts: sticky status, write one to clear, set wins
  // ---------------------------------------------------------------
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_mask;
  logic [INT_W-1:0] int_set;
  logic [INT_W-1:0] int_clr;

  assign int_set = {giveup_evt, jam_evt};
  assign int_clr = (wr_en && wr_strb[0] && wr_addr == OFS_INT_STAT)
                   ? wr_data[INT_W-1:0] : '0;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      int_stat <= '0;
    else
      int_stat <= (int_stat & ~int_clr) | int_set;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      int_mask <= '0;
    else if (wr_en && wr_strb[0] && wr_addr == OFS_INT_MASK)
      int_mask <= wr_data[INT_W-1:0];
  end

  assign irq = |(int_stat & int_mask);

  // ---------------------------------------------------------------
  // read mux, registered inside the bus front end
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_data = '0;
    if (rd_addr == OFS_INT_STAT)
      rd_data[INT_W-1:0] = int_stat;
    if (rd_addr == OFS_INT_MASK)
      rd_data[INT_W-1:0] = int_mask;
    for (int z = 0; z < ZONES; z++)
    begin
      if (zreg(rd_addr, 1'(z), OFS_CTRL))
        rd_data[4:0] = {accum[z], acdis[z], tzone_en[z], mode[z]};
      if (zreg(rd_addr, 1'(z), OFS_GAP))
        rd_data[TW-1:0] = gap_time[z];
      if (zreg(rd_addr, 1'(z), OFS_ACCEPT))
        rd_data[TW-1:0] = accept_time[z];
      if (zreg(rd_addr, 1'(z), OFS_JAMT))
        rd_data[TW-1:0] = jam_time[z];
      if (zreg(rd_addr, 1'(z), OFS_STAT))
        rd_data[TW-1:0] = stat_word[z];
      if (zreg(rd_addr, 1'(z), OFS_JCNT))
        rd_data[JCW-1:0] = jam_cnt[z];
    end
  end

endmodule

// ==== tb/zrc_conv_model.sv ====
module zrc_conv_model
  import zrc_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [ZONES-1:0] put,
  input  wire logic [ZONES-1:0] motor_run,
  output logic [ZONES-1:0]      sensor_blocked
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------
  // carton on the zone sensor
  // -------------------------------------------------------------
  // a carton stays on the eye until its motor carries it off;
  // holding put high models a carton stuck against the sensor
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      sensor_blocked <= '0;
    else
      sensor_blocked <= put | (sensor_blocked & ~motor_run);
endmodule

// ==== tb/zrc_chk_assertions.sv ====
module zrc_chk
  import zrc_pkg::*;
(
  input wire logic             mclk,
  input wire logic             reset_n,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic [ZONES-1:0] arrival_jam,
  input wire logic [ZONES-1:0] jam_active,
  input wire logic [ZONES-1:0] zone_release,
  input wire logic [ZONES-1:0] nv_save,
  input wire logic [ZONES-1:0] nv_accum_out,
  input wire logic [ZONES-1:0] motor_run
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------
  // port checks, one clock domain
  // -------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_arrival_jam: assert property (arrival_jam[0] |=> jam_active[0])
    else $error("arrival jam not shown");
  a_accum_hold: assert property (nv_accum_out[0] && !motor_run[0]
    && !jam_active[0] |=> !motor_run[0]) else $error("held carton moved");
  a_save_pulse: assert property (nv_save[0] |=> !nv_save[0])
    else $error("save strobe too long");
  a_rel_pulse: assert property (zone_release[0] |=> !zone_release[0])
    else $error("release strobe too long");
  a_rel_motor: assert property (zone_release[0] |-> motor_run[0])
    else $error("release without motor");
  a_read_lat: assert property (s_axi_arvalid && s_axi_arready
    |=> !s_axi_arready ##[0:1] s_axi_rvalid) else $error("read late");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_lat: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready && !s_axi_bvalid |=> ##[0:1] s_axi_bvalid)
    else $error("write late");
endmodule
bind zrc_zone_ctrl zrc_chk u_chk (.*);

// ==== tb/test_zrc_zone_ctrl.sv ====
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h expected %h", $time, g, e); end end
module test_zrc_zone_ctrl import zrc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------
  // bench signals, named as the ports so instances use .*
  // -------------------------------------------------------------
  logic             mclk = '0, reset_n = '0, irq;
  logic [AW-1:0]    s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]      s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]       s_axi_wstrb = 4'hF;
  logic             s_axi_awvalid = '0, s_axi_wvalid = '0;
  logic             s_axi_bready = '0, s_axi_arvalid = '0;
  logic             s_axi_rready = '0, s_axi_awready, s_axi_wready;
  logic             s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]       s_axi_bresp, s_axi_rresp;
  logic [ZONES-1:0] put = '0, ds_clear = '0, ds_release = '0;
  logic [ZONES-1:0] arrival_jam = '0, nv_accum_in = '0, sensor_blocked;
  logic [ZONES-1:0] motor_run, zone_release, zone_empty, jam_active;
  logic [ZONES-1:0] nv_accum_out, nv_save;
  int               fails = 0, n_tests = 0, i;
  // short tick so the timers finish in a few cycles
  zrc_zone_ctrl #(.TICK_CYC(4)) u_dut (.*);
  zrc_conv_model u_mdl (.*);
  always #4 mclk = ~mclk;
  // write with address and data offered together
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  // read one word and compare data and response
  task automatic rchk(input logic [AW-1:0] a, input logic [31:0] e,
                      input logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, e)
    `CHK(s_axi_rresp, r)
  endtask
  task automatic t_regs;
    rchk(OFS_CTRL, {30'h0, MODE_SINGLE}, RESP_OKAY);
    rchk(OFS_JAMT, {16'h0, JAMT_RST}, RESP_OKAY);
    rchk(ZONE_STRIDE + OFS_JCNT, 32'h0, RESP_OKAY);
    rchk(8'hFC, 32'h0, RESP_SLVERR);
    wr(ZONE_STRIDE + OFS_CTRL, {30'h0, MODE_TRAIN});
    rchk(ZONE_STRIDE + OFS_CTRL, 32'h1, RESP_OKAY);
    wr(ZONE_STRIDE + OFS_GAP, 32'h19);
    rchk(ZONE_STRIDE + OFS_GAP, 32'h19, RESP_OKAY);
    rchk(OFS_CTRL, 32'h0, RESP_OKAY);
    $display("test regs done");
  endtask
  // zone 1 is still in train mode and waits with no room downstream
  task automatic t_accum;
    ds_clear <= 2'h1;
    wr(OFS_CTRL, 32'h10);
    `CHK(nv_accum_out[0], 1'b1)
    put <= 2'h3;
    @(posedge mclk);
    put <= 2'h0;
    repeat (40) @(posedge mclk);
    `CHK(sensor_blocked & ~motor_run, 2'h3)
    ds_release <= 2'h2;
    wr(OFS_CTRL, 32'h0);
    `CHK(zone_empty[1], 1'b1)
    ds_clear <= 2'h3;
    for (i = 0; i < 20 && motor_run[0] !== 1'b1; i++) @(posedge mclk);
    `CHK(motor_run[0], 1'b1)
    repeat (4) @(posedge mclk);
    `CHK(zone_empty[0], 1'b1)
    $display("test accum done");
  endtask
  // stuck carton with auto clear off; only the jam bit is unmasked
  task automatic t_jam;
    wr(OFS_INT_MASK, 32'h2);
    wr(ZONE_STRIDE + OFS_JAMT, 32'h2);
    wr(ZONE_STRIDE + OFS_CTRL, 32'h8);
    put[1] <= 1'b1;
    for (i = 0; i < 100 && jam_active[1] !== 1'b1; i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    `CHK({jam_active[1], motor_run[1], irq}, 3'h5)
    rchk(ZONE_STRIDE + OFS_JCNT, 32'h1, RESP_OKAY);
    put[1] <= 1'b0;
    wr(ZONE_STRIDE + OFS_CMD, 32'h1);
    `CHK(jam_active[1], 1'b0)
    wr(OFS_INT_STAT, 32'h2);
    `CHK(irq, 1'b0)
    $display("test jam done");
  endtask
  task automatic t_arrival;
    arrival_jam[0] <= 1'b1;
    repeat (3) @(posedge mclk);
    `CHK(jam_active[0], 1'b1)
    arrival_jam[0] <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK(jam_active[0], 1'b0)
    rchk(OFS_JCNT, 32'h1, RESP_OKAY);
    $display("test arrival done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_accum();
    t_jam();
    t_arrival();
    test_done();
  end
  // the tests need well under a thousand cycles
  initial
  begin
    #50us;
    fails++;
    test_done();
  end
endmodule
